/* File: rtl/icr_input_cond.sv */
// one capture input: synchroniser, optional noise filter, edge pick
`timescale 1ns/1ps
module icr_input_cond
    import icr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sig_in, // raw asynchronous input
    input wire logic filt_en, // filter on
    input wire logic [1:0] edge_sel, // edge code
    output logic event_pulse // one-cycle capture event
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sync1; // first synchroniser stage
        logic sync2; // second synchroniser stage
        logic [2:0] cnt; // filter stability count
        logic lvl; // qualified level
        logic prev; // qualified level one cycle back
        logic evt; // registered event
    } icr_cond_t;

    icr_cond_t st_q;
    icr_cond_t st_d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.sync1 = sig_in;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.lvl;
        // filter: level moves only after staying changed long enough
        if (!filt_en) begin
            st_d.lvl = st_q.sync2;
            st_d.cnt = 3'h0;
        end else if (st_q.sync2 == st_q.lvl) begin
            st_d.cnt = 3'h0;
        end else if (st_q.cnt == FILT_LAST) begin
            st_d.lvl = st_q.sync2;
            st_d.cnt = 3'h0;
        end else begin
            st_d.cnt = st_q.cnt + 3'h1;
        end
        // edge pick on the qualified level, reserved code is silent
        case (icr_edge_t'(edge_sel))
            EDGE_RISE: st_d.evt = st_q.lvl & ~st_q.prev;
            EDGE_FALL: st_d.evt = ~st_q.lvl & st_q.prev;
            EDGE_BOTH: st_d.evt = st_q.lvl ^ st_q.prev;
            default: st_d.evt = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign event_pulse = st_q.evt;

endmodule

/* File: rtl/icr_pkg.sv */
// shared constants and types of the input capture / reload block
package icr_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_EDGE_RELOAD = 8'ha3; // capture_edge_reload_control
    localparam logic [7:0] IDX_SRC_FLAGS = 8'ha4; // capture_source_filter_flags
    localparam logic [7:0] IDX_CAP2_LO = 8'ha6; // capture2_value_low
    localparam logic [7:0] IDX_CAP2_HI = 8'ha7; // capture2_value_high
    localparam logic [7:0] IDX_IRQ_MASK = 8'hb0; // interrupt mask
    localparam logic [7:0] IDX_CAP0_LO = 8'hb1; // capture0 value low
    localparam logic [7:0] IDX_CAP0_HI = 8'hb2; // capture0 value high
    localparam logic [7:0] IDX_CAP1_LO = 8'hb3; // capture1 value low
    localparam logic [7:0] IDX_CAP1_HI = 8'hb4; // capture1 value high

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int POS_CH2_EDGE = 6; // chan2_edge_select lsb
    localparam int POS_CH1_EDGE = 4; // chan1_edge_select lsb
    localparam int POS_CH0_EDGE = 2; // chan0_edge_select lsb
    localparam int POS_RELOAD = 0; // reload_trigger_select lsb
    localparam int POS_SRC_SEL = 6; // chan0_source_select
    localparam int POS_FILT = 3; // chanN_filter_enable, 3 bits
    localparam int POS_FLAGS = 0; // chanN_event_flag, 3 bits

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_EDGE_RELOAD = 8'h00; // control 0
    localparam logic [7:0] RST_SRC_FLAGS = 8'h00; // control 1
    localparam logic [15:0] RST_CAPTURE = 16'h0000; // capture pairs
    localparam logic [2:0] RST_MASK = 3'h0; // all masked
    localparam logic [31:0] RST_RDATA = 32'h0000_0000; // read data

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10; // clk_sys period
    localparam int FILT_TIME_NS = 40; // least stable time through filter
    localparam int FILT_CYCLES = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] FILT_LAST = 3'(FILT_CYCLES - 1); // counter end

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        EDGE_RISE = 2'h0, // rising edge
        EDGE_FALL = 2'h1, // falling edge
        EDGE_BOTH = 2'h2, // both edges
        EDGE_RSVD = 2'h3 // reserved, never triggers
    } icr_edge_t;

    typedef enum logic [1:0] {
        RLD_OVERFLOW = 2'h0, // timer 2 overflow
        RLD_CAP0 = 2'h1, // capture channel 0 event
        RLD_CAP1 = 2'h2, // capture channel 1 event
        RLD_CAP2 = 2'h3 // capture channel 2 event
    } icr_reload_t;

    typedef enum logic {
        BUS_IDLE = 1'b0, // waiting for a request
        BUS_ACK = 1'b1 // answering, waitrequest low
    } icr_bus_t;

endpackage

/* File: rtl/icr_top.sv */
// three-channel input capture and timer reload control, Avalon-MM slave
`timescale 1ns/1ps
module icr_top
    import icr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] cap_pin,
    input wire logic adc_compare_result,
    input wire logic [15:0] timer_count,
    input wire logic timer_overflow,
    output logic timer_reload,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        icr_bus_t bus; // bus answer phase
        logic [31:0] rdata; // read data held for the answer
        logic [7:0] ctl0; // capture_edge_reload_control
        logic src_sel; // chan0_source_select
        logic [2:0] filt_en; // chanN_filter_enable
        logic [2:0] flags; // chanN_event_flag
        logic [2:0] mask; // interrupt mask
        logic [2:0][15:0] cap; // capture value per channel
        logic reload; // timer reload pulse
    } icr_state_t;

    icr_state_t st_q;
    icr_state_t st_d;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // true when the byte address selects a register index
    function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
        reg_hit = (addr[9:2] == idx);
    endfunction

    // control 1 as software sees it, reserved bit 7 reads zero
    function automatic logic [7:0] src_flags_view(input icr_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[POS_SRC_SEL] = s.src_sel;
        v[POS_FILT +: 3] = s.filt_en;
        v[POS_FLAGS +: 3] = s.flags;
        src_flags_view = v;
    endfunction

    // read mux over all registers, unmapped reads zero
    function automatic logic [7:0] reg_read(input logic [9:0] addr, input icr_state_t s);
        logic [7:0] v;
        v = 8'h00;
        if (reg_hit(addr, IDX_EDGE_RELOAD)) begin
            v = s.ctl0;
        end else if (reg_hit(addr, IDX_SRC_FLAGS)) begin
            v = src_flags_view(s);
        end else if (reg_hit(addr, IDX_CAP2_LO)) begin
            v = s.cap[2][7:0];
        end else if (reg_hit(addr, IDX_CAP2_HI)) begin
            v = s.cap[2][15:8];
        end else if (reg_hit(addr, IDX_IRQ_MASK)) begin
            v = {5'h00, s.mask};
        end else if (reg_hit(addr, IDX_CAP0_LO)) begin
            v = s.cap[0][7:0];
        end else if (reg_hit(addr, IDX_CAP0_HI)) begin
            v = s.cap[0][15:8];
        end else if (reg_hit(addr, IDX_CAP1_LO)) begin
            v = s.cap[1][7:0];
        end else if (reg_hit(addr, IDX_CAP1_HI)) begin
            v = s.cap[1][15:8];
        end
        reg_read = v;
    endfunction

    // ----------------------------------------------------------------
    // input conditioning per channel
    // ----------------------------------------------------------------
    logic [2:0] cap_src; // selected raw input per channel
    logic [2:0] cap_evt; // qualified capture events
    logic [2:0][1:0] edge_sel; // edge code per channel

    // channel 0 source is pin or adc compare result
    assign cap_src[0] = st_q.src_sel ? adc_compare_result : cap_pin[0];
    assign cap_src[1] = cap_pin[1];
    assign cap_src[2] = cap_pin[2];

    // edge fields taken straight from control 0
    assign edge_sel[2] = st_q.ctl0[POS_CH2_EDGE +: 2];
    assign edge_sel[1] = st_q.ctl0[POS_CH1_EDGE +: 2];
    assign edge_sel[0] = st_q.ctl0[POS_CH0_EDGE +: 2];

    // one conditioner per channel, each synchronises its own input
    for (genvar ch = 0; ch < 3; ch++) begin : g_ch
        icr_input_cond u_cond (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .sig_in(cap_src[ch]),
            .filt_en(st_q.filt_en[ch]),
            .edge_sel(edge_sel[ch]),
            .event_pulse(cap_evt[ch])
        );
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic bus_req; // a read or write is pending
    logic wr_now; // write takes effect this edge
    logic wr_lane0; // low byte lane enabled
    logic [7:0] wr_byte; // write data byte

    assign bus_req = avs_read | avs_write;
    assign wr_now = avs_write & (st_q.bus == BUS_ACK);
    assign wr_lane0 = avs_byteenable[0];
    assign wr_byte = avs_writedata[7:0];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        // bus answer: one wait cycle, then one answer cycle
        case (st_q.bus)
            BUS_IDLE: begin
                // sample read data while waitrequest is high
                if (bus_req) begin
                    st_d.bus = BUS_ACK;
                    st_d.rdata = {24'h000000, reg_read(avs_address, st_q)};
                end
            end
            BUS_ACK: begin
                // answer taken at this edge, back to idle
                st_d.bus = BUS_IDLE;
            end
            default: begin
                st_d.bus = BUS_IDLE;
            end
        endcase

        // register writes at the answering edge
        if (wr_now && wr_lane0) begin
            if (reg_hit(avs_address, IDX_EDGE_RELOAD)) begin
                st_d.ctl0 = wr_byte;
            end
            if (reg_hit(avs_address, IDX_SRC_FLAGS)) begin
                st_d.src_sel = wr_byte[POS_SRC_SEL];
                st_d.filt_en = wr_byte[POS_FILT +: 3];
                // flags clear by writing ones
                st_d.flags = st_q.flags & ~wr_byte[POS_FLAGS +: 3];
            end
            if (reg_hit(avs_address, IDX_IRQ_MASK)) begin
                st_d.mask = wr_byte[2:0];
            end
            if (reg_hit(avs_address, IDX_CAP2_LO)) begin
                st_d.cap[2][7:0] = wr_byte;
            end
            if (reg_hit(avs_address, IDX_CAP2_HI)) begin
                st_d.cap[2][15:8] = wr_byte;
            end
            if (reg_hit(avs_address, IDX_CAP0_LO)) begin
                st_d.cap[0][7:0] = wr_byte;
            end
            if (reg_hit(avs_address, IDX_CAP0_HI)) begin
                st_d.cap[0][15:8] = wr_byte;
            end
            if (reg_hit(avs_address, IDX_CAP1_LO)) begin
                st_d.cap[1][7:0] = wr_byte;
            end
            if (reg_hit(avs_address, IDX_CAP1_HI)) begin
                st_d.cap[1][15:8] = wr_byte;
            end
        end

        // capture events latch the count and raise the flag;
        // applied after writes so a set beats a same-cycle clear
        for (int ch = 0; ch < 3; ch++) begin
            if (cap_evt[ch]) begin
                st_d.cap[ch] = timer_count;
                st_d.flags[ch] = 1'b1;
            end
        end

        // reload source pick
        case (icr_reload_t'(st_q.ctl0[POS_RELOAD +: 2]))
            RLD_OVERFLOW: st_d.reload = timer_overflow;
            RLD_CAP0: st_d.reload = cap_evt[0];
            RLD_CAP1: st_d.reload = cap_evt[1];
            RLD_CAP2: st_d.reload = cap_evt[2];
            default: st_d.reload = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q.bus <= BUS_IDLE;
            st_q.rdata <= RST_RDATA;
            st_q.ctl0 <= RST_EDGE_RELOAD;
            st_q.src_sel <= RST_SRC_FLAGS[POS_SRC_SEL];
            st_q.filt_en <= RST_SRC_FLAGS[POS_FILT +: 3];
            st_q.flags <= RST_SRC_FLAGS[POS_FLAGS +: 3];
            st_q.mask <= RST_MASK;
            st_q.cap <= {3{RST_CAPTURE}};
            st_q.reload <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // waitrequest low in the answer cycle and while no request is pending
    assign avs_waitrequest = bus_req & (st_q.bus != BUS_ACK);
    // read data from flip-flops
    assign avs_readdata = st_q.rdata;
    // reload pulse from flip-flop
    assign timer_reload = st_q.reload;
    // level interrupt while any unmasked flag is set
    assign irq = |(st_q.flags & st_q.mask);

endmodule

/* File: verif/icr_far_model.sv */
// far side: capture pins, comparator result and a shortened timer 2
`timescale 1ns/1ps
module icr_far_model #(
    parameter logic [15:0] TMR_TOP = 16'h0fff, // wrap point, shortened
    parameter logic [15:0] TMR_LOAD = 16'h0f00 // reload value
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] pin_req,
    input wire logic adc_req,
    input wire logic tmr_hold,
    input wire logic timer_reload,
    output logic [2:0] cap_pin,
    output logic adc_compare_result,
    output logic [15:0] timer_count,
    output logic timer_overflow,
    output logic [15:0] reload_cnt,
    output logic [15:0] ovf_cnt
);
    // pins follow the levels the bench asks for
    assign cap_pin = pin_req;
    assign adc_compare_result = adc_req;
    // timer: reload wins, else count unless frozen
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_count <= TMR_LOAD;
            timer_overflow <= 1'b0;
            reload_cnt <= 16'h0;
            ovf_cnt <= 16'h0;
        end else begin
            timer_overflow <= 1'b0;
            if (timer_reload) begin
                timer_count <= TMR_LOAD;
                reload_cnt <= reload_cnt + 16'h1;
            end else if (!tmr_hold) begin
                timer_count <= (timer_count == TMR_TOP) ? 16'h0 : timer_count + 16'h1;
                if (timer_count == TMR_TOP) begin
                    timer_overflow <= 1'b1;
                    ovf_cnt <= ovf_cnt + 16'h1;
                end
            end
        end
    end
endmodule

/* File: verif/icr_top_checker.sv */
// port-level assertions for the capture and reload block
`timescale 1ns/1ps
module icr_top_checker
    import icr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] cap_pin,
    input wire logic adc_compare_result,
    input wire logic [15:0] timer_count,
    input wire logic timer_overflow,
    input wire logic timer_reload,
    input wire logic irq
);
    // ----------------------------------------------------------------
    // shadow of the reload select and mask
    // ----------------------------------------------------------------
    logic [1:0] sel_q; // reload trigger select
    logic [2:0] mask_q; // interrupt mask
    logic wr_ok; // write accepted at this edge
    assign wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
    // follow accepted writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 2'h0;
            mask_q <= 3'h0;
        end else if (wr_ok) begin
            if (avs_address[9:2] == IDX_EDGE_RELOAD) begin
                sel_q <= avs_writedata[1:0];
            end
            if (avs_address[9:2] == IDX_IRQ_MASK) begin
                mask_q <= avs_writedata[2:0];
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_req_waits;
        $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest;
    endproperty
    property p_read_ack;
        avs_read && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_write_ack;
        avs_write && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_idle_free;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    property p_one_ack;
        !avs_waitrequest && avs_read |=> avs_waitrequest || !avs_read;
    endproperty
    property p_rdata_upper;
        avs_readdata[31:8] == 24'h0;
    endproperty
    property p_rdata_hold;
        !avs_waitrequest && avs_read |=> $stable(avs_readdata);
    endproperty
    property p_ovf_reload;
        timer_overflow && sel_q == 2'h0 |=> timer_reload;
    endproperty
    property p_irq_masked;
        mask_q == 3'h0 ##1 mask_q == 3'h0 |-> !irq;
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    a_req_waits: assert property (p_req_waits) else $error("request not held off");
    a_read_ack: assert property (p_read_ack) else $error("read answer late");
    a_write_ack: assert property (p_write_ack) else $error("write answer late");
    a_idle_free: assert property (p_idle_free) else $error("wait while idle");
    a_one_ack: assert property (p_one_ack) else $error("answer longer than one cycle");
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read data set");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_ovf_reload: assert property (p_ovf_reload) else $error("overflow reload missed");
    a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    c_reload: cover property (timer_reload);
    c_irq: cover property (irq);
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind icr_top icr_top_checker i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cap_pin(cap_pin),
    .adc_compare_result(adc_compare_result), .timer_count(timer_count),
    .timer_overflow(timer_overflow), .timer_reload(timer_reload), .irq(irq));

/* File: verif/testbench.sv */
// self-checking bench for the capture and reload block
`timescale 1ns/1ps
module testbench;
    import icr_pkg::*;
    logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, adc_compare_result;
    logic timer_overflow, timer_reload, irq, adc_req, tmr_hold;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [2:0] cap_pin, pin_req;
    logic [15:0] timer_count, reload_cnt, ovf_cnt;
    int fails, checks;
    icr_top i_icr_top (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cap_pin(cap_pin),
        .adc_compare_result(adc_compare_result), .timer_count(timer_count),
        .timer_overflow(timer_overflow), .timer_reload(timer_reload), .irq(irq));
    icr_far_model i_icr_far_model (.clk_sys(clk_sys), .rst_n(rst_n), .pin_req(pin_req),
        .adc_req(adc_req), .tmr_hold(tmr_hold), .timer_reload(timer_reload),
        .cap_pin(cap_pin), .adc_compare_result(adc_compare_result),
        .timer_count(timer_count), .timer_overflow(timer_overflow),
        .reload_cnt(reload_cnt), .ovf_cnt(ovf_cnt));
    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one bus transfer, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
        input logic [3:0] be, output logic [7:0] rd);
        int n;
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, wd};
        avs_byteenable <= be;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (!avs_waitrequest) break;
        end
        if (n == 50) begin
            fails++;
            stop_test();
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        xfer(1'b1, idx, d, 4'h1, x);
    endtask
    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        xfer(1'b0, idx, 8'h00, 4'h1, x);
        chk(what, {8'h00, x}, {8'h00, exp});
    endtask
    // pin 3 stands for the comparator result; w cycles pass afterwards
    task automatic pin_set(input int ch, input logic v, input int w);
        @(posedge clk_sys);
        if (ch == 3) adc_req <= v;
        else pin_req[ch] <= v;
        repeat (w) @(posedge clk_sys);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] x;
        rdchk("ctrl0 rst", IDX_EDGE_RELOAD, RST_EDGE_RELOAD);
        rdchk("ctrl1 rst", IDX_SRC_FLAGS, RST_SRC_FLAGS);
        rdchk("cap2 lo rst", IDX_CAP2_LO, 8'h00);
        rdchk("cap2 hi rst", IDX_CAP2_HI, 8'h00);
        wr8(8'h10, 8'hff);
        rdchk("unmapped", 8'h10, 8'h00);
        wr8(IDX_EDGE_RELOAD, 8'ha5);
        wr8(IDX_CAP2_LO, 8'h5a);
        xfer(1'b1, IDX_EDGE_RELOAD, 8'h00, 4'h0, x);
        rdchk("ctrl0 rw", IDX_EDGE_RELOAD, 8'ha5);
        rdchk("cap2 lo rw", IDX_CAP2_LO, 8'h5a);
        wr8(IDX_SRC_FLAGS, 8'hff);
        rdchk("ctrl1 rw", IDX_SRC_FLAGS, 8'h78);
        wr8(IDX_SRC_FLAGS, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_edges();
        logic [7:0] f;
        tmr_hold <= 1'b1;
        for (int ch = 0; ch < 3; ch++) begin
            for (int c = 0; c < 3; c++) begin
                f = 8'(1 << ch);
                wr8(IDX_EDGE_RELOAD, 8'(c << (2 * ch + 2)));
                pin_set(ch, 1'b1, 14);
                rdchk("flag rise", IDX_SRC_FLAGS, (c == 0 || c == 2) ? f : 8'h0);
                wr8(IDX_SRC_FLAGS, 8'h07);
                pin_set(ch, 1'b0, 14);
                rdchk("flag fall", IDX_SRC_FLAGS, (c == 1 || c == 2) ? f : 8'h0);
                wr8(IDX_SRC_FLAGS, 8'h07);
            end
        end
        rdchk("cap2 lo", IDX_CAP2_LO, timer_count[7:0]);
        rdchk("cap2 hi", IDX_CAP2_HI, timer_count[15:8]);
        $display("test edges done");
    endtask
    task automatic t_source();
        wr8(IDX_EDGE_RELOAD, 8'h00);
        wr8(IDX_SRC_FLAGS, 8'h47);
        pin_set(3, 1'b1, 14);
        rdchk("adc source", IDX_SRC_FLAGS, 8'h41);
        wr8(IDX_SRC_FLAGS, 8'h47);
        pin_set(0, 1'b1, 14);
        rdchk("pin ignored", IDX_SRC_FLAGS, 8'h40);
        pin_set(3, 1'b0, 2);
        pin_set(0, 1'b0, 14);
        wr8(IDX_SRC_FLAGS, 8'h07);
        $display("test source done");
    endtask
    task automatic t_filter();
        wr8(IDX_EDGE_RELOAD, 8'ha8);
        for (int ch = 0; ch < 3; ch++) begin
            wr8(IDX_SRC_FLAGS, 8'(8'h07 | (8'h08 << ch)));
            pin_set(ch, 1'b1, 2);
            pin_set(ch, 1'b0, 14);
            rdchk("pulse filtered", IDX_SRC_FLAGS, 8'(8'h08 << ch));
            wr8(IDX_SRC_FLAGS, 8'h07);
            pin_set(ch, 1'b1, 2);
            pin_set(ch, 1'b0, 14);
            rdchk("pulse raw", IDX_SRC_FLAGS, 8'(1 << ch));
            wr8(IDX_SRC_FLAGS, 8'h07);
        end
        $display("test filter done");
    endtask
    task automatic t_reload();
        logic [15:0] n, o;
        for (int s = 1; s < 4; s++) begin
            wr8(IDX_EDGE_RELOAD, 8'(s));
            n = reload_cnt;
            pin_set(s - 1, 1'b1, 14);
            chk("reload on event", reload_cnt, n + 16'h1);
            pin_set(s - 1, 1'b0, 14);
            chk("no reload on fall", reload_cnt, n + 16'h1);
        end
        wr8(IDX_EDGE_RELOAD, 8'h00);
        wr8(IDX_SRC_FLAGS, 8'h07);
        n = reload_cnt;
        o = ovf_cnt;
        tmr_hold <= 1'b0;
        repeat (600) @(posedge clk_sys);
        tmr_hold <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("overflow seen", 16'(ovf_cnt != o), 16'h1);
        chk("reload per overflow", reload_cnt - n, ovf_cnt - o);
        $display("test reload done");
    endtask
    task automatic t_irq();
        wr8(IDX_IRQ_MASK, 8'h02);
        rdchk("mask rw", IDX_IRQ_MASK, 8'h02);
        pin_set(0, 1'b1, 14);
        chk("masked event", {15'h0, irq}, 16'h0);
        pin_set(1, 1'b1, 14);
        chk("irq on", {15'h0, irq}, 16'h1);
        wr8(IDX_IRQ_MASK, 8'h00);
        pin_set(1, 1'b1, 2);
        chk("irq masked", {15'h0, irq}, 16'h0);
        wr8(IDX_IRQ_MASK, 8'h02);
        pin_set(1, 1'b1, 2);
        chk("irq unmasked", {15'h0, irq}, 16'h1);
        wr8(IDX_SRC_FLAGS, 8'h03);
        pin_set(1, 1'b1, 2);
        chk("irq cleared", {15'h0, irq}, 16'h0);
        rdchk("flags cleared", IDX_SRC_FLAGS, 8'h00);
        $display("test irq done");
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        fails = 0;
        checks = 0;
        rst_n = 1'b0;
        avs_address = 10'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        pin_req = 3'h0;
        adc_req = 1'b0;
        tmr_hold = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_edges();
        t_source();
        t_filter();
        t_reload();
        t_irq();
        stop_test();
    end
endmodule
